//--- logic/tac_pkg.sv
// constants and types for the tracking converter up/down control
// Operation
// - both comparators high: hold count, assert ready
// - imbalance: count toward balance, direction from comparator
// - ready changes only on balance lost/regained
// - counter is eight bits, acquisition up to 256
// - counter moves at most one step per clock
// - negative-output mode: result presented bit-inverted
package tac_pkg;
    localparam int CODE_W = 8;
    localparam logic [7:0] CODE_MIN = 8'h00;
    localparam logic [7:0] CODE_MAX = 8'hFF;
    localparam logic [7:0] CODE_RST = 8'h80;
    localparam logic [7:0] CODE_ONE = 8'h01;
    localparam int SYNC_STAGES = 2;

    typedef struct packed {
        logic below;
        logic above;
    } tac_cmp_s;

    typedef struct packed {
        tac_cmp_s meta;
        tac_cmp_s sync;
    } tac_sync_state_s;

    typedef struct packed {
        logic [7:0] count;
        logic ready;
    } tac_core_state_s;
endpackage

//--- logic/tac_sync.sv
// two-flop synchroniser for the window comparator pair
`timescale 1ns/10ps
module tac_sync (
    input wire logic sys_clk,
    input wire logic rst,
    input wire tac_pkg::tac_cmp_s cmp_in,
    output tac_pkg::tac_cmp_s cmp_out
);
    tac_pkg::tac_sync_state_s st;
    tac_pkg::tac_sync_state_s next_st;

    always_comb begin
        next_st.meta = cmp_in;
        next_st.sync = st.meta;
    end

    // reset to "not balanced" so the counter does not park falsely
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign cmp_out = st.sync;

    a_sync_delay: assert property (@(posedge sys_clk) disable iff (rst)
        !$past(rst, 2) |-> cmp_out == $past(cmp_in, 2))
        else $error("comparator sync delay not two cycles");
endmodule

//--- logic/tac_ctrl.sv
// up/down counter control of a tracking analog-to-digital converter
`timescale 1ns/10ps
module tac_ctrl (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic cmp_below,
    input wire logic cmp_above,
    input wire logic neg_mode,
    output logic [7:0] dac_code,
    output logic [7:0] result,
    output logic data_ready
);
    tac_pkg::tac_cmp_s cmp_raw;
    tac_pkg::tac_cmp_s cmp;
    tac_pkg::tac_core_state_s st;
    tac_pkg::tac_core_state_s next_st;
    logic balanced;
    logic go_up;
    logic go_down;

    assign cmp_raw.below = cmp_below;
    assign cmp_raw.above = cmp_above;

    tac_sync u_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .cmp_in(cmp_raw),
        .cmp_out(cmp)
    );

    // each comparator goes low when the imbalance passes its threshold
    assign balanced = cmp.below & cmp.above;
    assign go_up = !cmp.below & cmp.above;
    assign go_down = cmp.below & !cmp.above;

    always_comb begin
        next_st = st;
        // ready is the balance flag, so it moves only on balance edges
        next_st.ready = balanced;
        // saturate: a stuck input at full scale must not wrap the code
        if (go_up && st.count != tac_pkg::CODE_MAX) begin
            next_st.count = st.count + tac_pkg::CODE_ONE;
        end else if (go_down && st.count != tac_pkg::CODE_MIN) begin
            next_st.count = st.count - tac_pkg::CODE_ONE;
        end
        // both low is a comparator fault: hold rather than guess
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st.count <= tac_pkg::CODE_RST;
            st.ready <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    // the ladder takes the raw count; mode wiring sets its meaning
    assign dac_code = st.count;
    // limitation: cascading uses only bits above the upper lowest input
    assign result = neg_mode ? ~st.count : st.count;
    assign data_ready = st.ready;

    a_hold_balance: assert property (@(posedge sys_clk) disable iff (rst)
        balanced |=> $stable(dac_code) && data_ready)
        else $error("count moved while balanced");
    a_step_up: assert property (@(posedge sys_clk) disable iff (rst)
        go_up && dac_code != 8'hFF |=> dac_code == $past(dac_code) + 8'h01)
        else $error("count did not step up");
    a_step_down: assert property (@(posedge sys_clk) disable iff (rst)
        go_down && dac_code != 8'h00 |=> dac_code == $past(dac_code) - 8'h01)
        else $error("count did not step down");
    a_ready_edge: assert property (@(posedge sys_clk) disable iff (rst)
        $changed(data_ready) |-> data_ready == $past(balanced))
        else $error("ready changed without balance change");
    a_one_step: assert property (@(posedge sys_clk) disable iff (rst)
        !$past(rst) |-> (dac_code - $past(dac_code) == 8'h01) ||
        ($past(dac_code) - dac_code == 8'h01) || $stable(dac_code))
        else $error("count moved more than one step");
    a_sat_top: assert property (@(posedge sys_clk) disable iff (rst)
        dac_code == 8'hFF && !go_down |=> dac_code == 8'hFF)
        else $error("count wrapped at top");
    a_sat_bottom: assert property (@(posedge sys_clk) disable iff (rst)
        dac_code == 8'h00 && !go_up |=> dac_code == 8'h00)
        else $error("count wrapped at bottom");
    a_neg_result: assert property (@(posedge sys_clk) disable iff (rst)
        neg_mode |-> result == ~dac_code)
        else $error("negative result not inverted");
    a_sync_path: assert property (@(posedge sys_clk) disable iff (rst)
        (cmp_below && cmp_above) [*3] |=> data_ready)
        else $error("ready not set after synchronised balance");
    // both comparators low cannot be balance, so the code must not move
    a_fault_hold: assert property (@(posedge sys_clk) disable iff (rst)
        !cmp.below && !cmp.above |=> $stable(dac_code) && !data_ready)
        else $error("count moved on comparator fault");
    a_pos_result: assert property (@(posedge sys_clk) disable iff (rst)
        !neg_mode |-> result == dac_code)
        else $error("positive result not plain count");
    a_ready_level: assert property (@(posedge sys_clk) disable iff (rst)
        !$past(rst) |-> data_ready == $past(balanced))
        else $error("ready does not follow balance");

    c_acquire: cover property (@(posedge sys_clk) disable iff (rst)
        !data_ready ##1 data_ready);
    c_lose: cover property (@(posedge sys_clk) disable iff (rst)
        data_ready ##1 !data_ready);
    c_top: cover property (@(posedge sys_clk) disable iff (rst)
        dac_code == 8'hFF);
    c_bottom: cover property (@(posedge sys_clk) disable iff (rst)
        dac_code == 8'h00);
endmodule

//--- test/tac_model.sv
// window comparator pair facing a positive-logic ladder converter
`timescale 1ns/10ps
module tac_model (
    input wire logic [7:0] dac_code,
    input wire logic signed [31:0] level,
    input wire logic signed [31:0] slack,
    output logic cmp_below,
    output logic cmp_above
);
    // a wide window absorbs the loop's sync lag overshoot
    // offset binary keeps the code order, so bipolar compares alike
    // a grounded-bus ladder would see the code inverted here
    // cascade: upper_unit_unused_input stays open, not modelled
    assign cmp_below = !(int'(dac_code) + slack < level);
    assign cmp_above = !(int'(dac_code) > level + slack);
endmodule

//--- test/testbench.sv
// self-checking bench for the tracking converter control
`timescale 1ns/10ps
module testbench;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic neg_mode = 1'b1;
    int level = 128;
    logic cmp_below, cmp_above, data_ready;
    logic [7:0] dac_code, result;
    int err_count = 0;
    int cmp_count = 0;
    logic ready_seen = 1'b0;
    logic chg_flag = 1'b0;
    logic flag_clear = 1'b0;
    tac_ctrl i_tac_ctrl (.sys_clk(sys_clk), .rst(rst), .cmp_below(cmp_below),
        .cmp_above(cmp_above), .neg_mode(neg_mode), .dac_code(dac_code),
        .result(result), .data_ready(data_ready));
    tac_model i_tac_model (.dac_code(dac_code), .level(level), .slack(3),
        .cmp_below(cmp_below), .cmp_above(cmp_above));
    initial begin
        forever #2.5 sys_clk = ~sys_clk;
    end
    // reader: a ready transition flags a change, cleared after read-out
    always @(posedge sys_clk) begin
        ready_seen <= data_ready;
        if (data_ready != ready_seen) begin
            chg_flag <= 1'b1;
        end else if (flag_clear) begin
            chg_flag <= 1'b0;
        end
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %0t saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run;
        $display("errors %0d compares %0d", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic run(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    // mid-scale start, then track level 0x90 one step per clock, settling at 0x8F
    task automatic acquire;
        check(dac_code, 8'h80);
        check(result, 8'h7F);
        check({7'h00, data_ready}, 8'h00);
        neg_mode = 1'b0;
        level = 144;
        run(3);
        check(dac_code, 8'h81);
        run(14);
        check(dac_code, 8'h8F);
        check({7'h00, data_ready}, 8'h00);
        run(1);
        check({7'h00, data_ready}, 8'h01);
        run(20);
        check(dac_code, 8'h8F);
        check(result, 8'h8F);
        check({7'h00, data_ready}, 8'h01);
        check({7'h00, chg_flag}, 8'h01);
        flag_clear = 1'b1;
        run(1);
        flag_clear = 1'b0;
        check({7'h00, chg_flag}, 8'h00);
        neg_mode = 1'b1;
        run(1);
        check(result, 8'h70);
    endtask
    // far targets pin the count at the ends without wrapping
    task automatic saturate;
        level = 300;
        run(3);
        check({7'h00, data_ready}, 8'h00);
        check(dac_code, 8'h90);
        run(300);
        check(dac_code, 8'hFF);
        check(result, 8'h00);
        level = -50;
        run(300);
        check(dac_code, 8'h00);
        check({7'h00, data_ready}, 8'h00);
    endtask
    initial begin
        run(10);
        rst = 1'b0;
        acquire();
        saturate();
        complete_run();
    end
    initial begin
        #15000;
        err_count++;
        complete_run();
    end
endmodule
